//--- logic/acd_diag_ctrl.sv
// Purpose: comparison diagnostic control with test current selection
// Assumes: readings arrive as flat buses from the converters, same clock
// Notes:   one scan visits every channel named by the relevant mask
// Summary of operation
// - current field drives pins one clock after it is written, no trigger needed
// - decode off, sense, balance, shunt source
// - selection captured only on trigger write
// - trigger one starts captured diagnostic
// - trigger reads zero, zero write ignored
// - codes zero and above five do nothing
// - cell check main versus aux delta
// - sense open wire main below threshold
// - balance open wire aux below threshold
// - switch check aux below main third
// - hold option keeps or drops switches
// - pin check main versus aux delta
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module acd_diag_ctrl (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic [acd_pkg::NUM_CH*16-1:0] main_cell_reading,
  input  wire logic [acd_pkg::NUM_CH*16-1:0] secondary_cell_reading,
  input  wire logic [acd_pkg::NUM_PIN*16-1:0] main_pin_reading,
  input  wire logic [acd_pkg::NUM_PIN*16-1:0] secondary_pin_reading,
  input  wire logic [acd_pkg::NUM_CH-1:0]    active_cell,
  input  wire logic [acd_pkg::NUM_PIN-1:0]   pin_analog_en,
  output logic      [acd_pkg::NUM_CH-1:0]    cell_sense_sink_en,
  output logic      [acd_pkg::NUM_CH-1:0]    balance_sink_en,
  output logic                               shunt_source_en,
  output logic      [acd_pkg::NUM_CH-1:0]    balance_switch,
  output logic                               irq
);
  import acd_pkg::*;

  logic                 wr_pend;
  logic [11:0]          wr_addr;
  logic                 rd_pend;
  logic [11:0]          rd_addr;
  logic [1:0]           test_current_select;
  logic                 switch_hold_after_test;
  logic [2:0]           sel_shadow;
  logic [2:0]           active_sel;
  logic [3:0]           open_wire_threshold;
  logic [4:0]           cell_delta_threshold;
  logic [2:0]           pin_delta_threshold;
  logic [NUM_CH-1:0]    aux_channel_select;
  logic [NUM_CH-1:0]    switch_test_mask;
  logic [NUM_DONE-1:0]  done_status;
  logic [NUM_DONE-1:0]  irq_mask;
  logic [NUM_CH-1:0]    fail_map;
  logic [3:0]           rdg_idx;
  logic [15:0]          rdg_dump;
  acd_state_t           state;
  logic [4:0]           ch;
  logic                 go_write;
  logic                 start_ok;
  logic [NUM_DONE-1:0]  done_set;
  logic [NUM_CH-1:0]    scan_mask;
  logic                 ch_enabled;
  logic                 scan_last;

  acd_cmp_if cmp_bus ();
  acd_compare u_cmp (.c(cmp_bus));

  function automatic logic valid_sel(input logic [2:0] s);
    valid_sel = (s >= SEL_CELL) && (s <= SEL_PIN);
  endfunction : valid_sel

  function automatic logic [15:0] pick16(input logic [NUM_CH*16-1:0] v, input logic [3:0] i);
    pick16 = v[i*16 +: 16];
  endfunction : pick16

  // address phase capture; single cycle data phase, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 12'h000;
      rd_addr <= 12'h000;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      rd_pend <= hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1]) begin
        wr_addr <= haddr[11:0];
        rd_addr <= haddr[11:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign go_write = wr_pend && (wr_addr == CTRL_OFS) && hwdata[GO_BIT];
  assign start_ok = go_write && valid_sel(hwdata[SEL_LSB +: 3]) && (state == ACD_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_current_select    <= TC_OFF;
      switch_hold_after_test <= 1'b0;
      sel_shadow             <= 3'h0;
    end else if (wr_pend && wr_addr == CTRL_OFS) begin
      test_current_select    <= hwdata[TC_LSB +: 2];
      switch_hold_after_test <= hwdata[HOLD_BIT];
      sel_shadow             <= hwdata[SEL_LSB +: 3];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cell_sense_sink_en <= '0;
      balance_sink_en    <= '0;
      shunt_source_en    <= 1'b0;
    end else begin
      cell_sense_sink_en <= {NUM_CH{test_current_select == TC_SENSE}};
      balance_sink_en    <= {NUM_CH{test_current_select == TC_BALANCE}};
      shunt_source_en    <= test_current_select == TC_SHUNT;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_wire_threshold  <= 4'h0;
      cell_delta_threshold <= 5'h00;
      pin_delta_threshold  <= 3'h0;
      aux_channel_select   <= '0;
      switch_test_mask     <= '0;
      irq_mask             <= '0;
      rdg_idx              <= 4'h0;
    end else if (wr_pend) begin
      case (wr_addr)
        THR_OFS: begin
          open_wire_threshold  <= hwdata[3:0];
          cell_delta_threshold <= hwdata[8:4];
          pin_delta_threshold  <= hwdata[11:9];
        end
        SEL_OFS:      aux_channel_select <= hwdata[NUM_CH-1:0];
        MASK_OFS:     switch_test_mask   <= hwdata[NUM_CH-1:0];
        IRQ_MASK_OFS: irq_mask           <= hwdata[NUM_DONE-1:0];
        RDG_IDX_OFS:  rdg_idx            <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_sel <= 3'h0;
    end else if (start_ok) begin
      active_sel <= hwdata[SEL_LSB +: 3];
    end
  end

  always_comb begin
    case (active_sel)
      SEL_SENSE_OW: scan_mask = active_cell;
      SEL_PIN:      scan_mask = {{(NUM_CH-NUM_PIN){1'b0}}, pin_analog_en};
      default:      scan_mask = aux_channel_select;
    endcase
  end

  assign ch_enabled = scan_mask[ch[3:0]];
  assign scan_last  = (ch == 5'(NUM_CH - 1));

  always_comb begin
    cmp_bus.mode     = active_sel;
    cmp_bus.thr      = 16'h0000;
    cmp_bus.main_rdg = pick16(main_cell_reading, ch[3:0]);
    cmp_bus.aux_rdg  = pick16(secondary_cell_reading, ch[3:0]);
    case (active_sel)
      SEL_CELL:     cmp_bus.thr = {11'h000, cell_delta_threshold};
      SEL_SENSE_OW: cmp_bus.thr = {12'h000, open_wire_threshold};
      SEL_BAL_OW: begin
        cmp_bus.thr      = {12'h000, open_wire_threshold};
        cmp_bus.main_rdg = pick16(secondary_cell_reading, ch[3:0]);
      end
      SEL_PIN: begin
        cmp_bus.thr      = {13'h0000, pin_delta_threshold};
        cmp_bus.main_rdg = main_pin_reading[ch[2:0]*16 +: 16];
        cmp_bus.aux_rdg  = secondary_pin_reading[ch[2:0]*16 +: 16];
      end
      default: ;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= ACD_IDLE;
      ch       <= 5'h00;
      fail_map <= '0;
      done_set <= '0;
    end else begin
      done_set <= '0;
      case (state)
        ACD_IDLE: begin
          if (start_ok) begin
            ch       <= 5'h00;
            fail_map <= '0;
            state    <= (hwdata[SEL_LSB +: 3] == SEL_SWITCH) ? ACD_SETTLE : ACD_SCAN;
          end
        end
        ACD_SETTLE: state <= ACD_SCAN;
        ACD_SCAN: begin
          if (ch_enabled && !cmp_bus.pass) begin
            fail_map[ch[3:0]] <= 1'b1;
          end
          ch <= ch + 5'h01;
          if (scan_last) begin
            state <= ACD_FINISH;
          end
        end
        ACD_FINISH: begin
          done_set[active_sel - 3'h1] <= 1'b1;
          state <= ACD_IDLE;
        end
        default: state <= ACD_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      balance_switch <= '0;
    end else if (state == ACD_IDLE && start_ok && hwdata[SEL_LSB +: 3] == SEL_SWITCH) begin
      balance_switch <= switch_test_mask;
    end else if (state == ACD_FINISH && active_sel == SEL_SWITCH && !switch_hold_after_test) begin
      balance_switch <= '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_status <= '0;
    end else begin
      for (int i = 0; i < NUM_DONE; i++) begin
        if (done_set[i]) begin
          done_status[i] <= 1'b1;
        end else if (wr_pend && wr_addr == STATUS_OFS && hwdata[i]) begin
          done_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(done_status & irq_mask);
    end
  end

  assign rdg_dump = pick16(main_cell_reading, rdg_idx);

  // trigger reads as zero
  // read word captured in the address phase; a write landing then shows next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        CTRL_OFS:     hrdata <= {25'h0, switch_hold_after_test, test_current_select,
                                 sel_shadow, 1'b0};
        THR_OFS:      hrdata <= {20'h0, pin_delta_threshold, cell_delta_threshold,
                                 open_wire_threshold};
        SEL_OFS:      hrdata <= {16'h0, aux_channel_select};
        MASK_OFS:     hrdata <= {16'h0, switch_test_mask};
        STATUS_OFS:   hrdata <= {26'h0, state != ACD_IDLE, done_status};
        IRQ_MASK_OFS: hrdata <= {27'h0, irq_mask};
        RESULT_OFS:   hrdata <= {16'h0, fail_map};
        RDG_IDX_OFS:  hrdata <= {28'h0, rdg_idx};
        RDG_DATA_OFS: hrdata <= {16'h0, rdg_dump};
        default:      hrdata <= 32'h0000_0000;
      endcase
    end else begin
      hrdata <= 32'h0000_0000;
    end
  end

  property p_sel_stable;
    @(posedge hclk) disable iff (!hresetn)
      (state == ACD_SCAN && !start_ok) |=> $stable(active_sel);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("selection changed mid scan");

  property p_current_decode;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (shunt_source_en == ($past(test_current_select) == TC_SHUNT))
               && (cell_sense_sink_en[0] == ($past(test_current_select) == TC_SENSE));
  endproperty
  a_current_decode: assert property (p_current_decode) else $error("current decode wrong");

  property p_current_prompt;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_addr == CTRL_OFS && hwdata[5:4] == TC_BALANCE) |=> ##1 balance_sink_en[0];
  endproperty
  a_current_prompt: assert property (p_current_prompt) else $error("sink not applied");

  property p_bad_sel;
    @(posedge hclk) disable iff (!hresetn)
      (go_write && !valid_sel(hwdata[3:1]) && state == ACD_IDLE) |=> state == ACD_IDLE;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("invalid selection started");

  property p_scan_len;
    @(posedge hclk) disable iff (!hresetn)
      (state == ACD_IDLE && start_ok && hwdata[3:1] != SEL_SWITCH) |=> ##17 done_set != '0;
  endproperty
  a_scan_len: assert property (p_scan_len) else $error("completion not raised");

  property p_sticky;
    @(posedge hclk) disable iff (!hresetn)
      (done_status[0] && !(wr_pend && wr_addr == STATUS_OFS && hwdata[0])) |=> done_status[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_go_zero;
    @(posedge hclk) disable iff (!hresetn)
      (rd_pend && rd_addr == CTRL_OFS) |-> hrdata[GO_BIT] == 1'b0;
  endproperty
  a_go_zero: assert property (p_go_zero) else $error("trigger read nonzero");

  property p_switch_drop;
    @(posedge hclk) disable iff (!hresetn)
      (state == ACD_FINISH && active_sel == SEL_SWITCH && !switch_hold_after_test)
        |=> balance_switch == '0;
  endproperty
  a_switch_drop: assert property (p_switch_drop) else $error("switches not released");

  property p_switch_on;
    @(posedge hclk) disable iff (!hresetn)
      (state == ACD_SETTLE) |-> balance_switch == switch_test_mask;
  endproperty
  a_switch_on: assert property (p_switch_on) else $error("switches not applied");
endmodule : acd_diag_ctrl
`default_nettype wire

//--- logic/acd_pkg.sv
// Purpose: shared constants and types for the comparison diagnostic control block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   offsets are byte addresses
package acd_pkg;
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] THR_OFS       = 12'h004;
  localparam logic [11:0] SEL_OFS       = 12'h008;
  localparam logic [11:0] MASK_OFS      = 12'h00C;
  localparam logic [11:0] STATUS_OFS    = 12'h010;
  localparam logic [11:0] IRQ_MASK_OFS  = 12'h014;
  localparam logic [11:0] RESULT_OFS    = 12'h018;
  localparam logic [11:0] RDG_IDX_OFS   = 12'h01C;
  localparam logic [11:0] RDG_DATA_OFS  = 12'h020;
  localparam int          NUM_CH        = 16;
  localparam int          NUM_PIN       = 8;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam int          GO_BIT        = 0;
  localparam int          SEL_LSB       = 1;
  localparam int          TC_LSB        = 4;
  localparam int          HOLD_BIT      = 6;
  localparam logic [2:0]  SEL_CELL      = 3'h1;
  localparam logic [2:0]  SEL_SENSE_OW  = 3'h2;
  localparam logic [2:0]  SEL_BAL_OW    = 3'h3;
  localparam logic [2:0]  SEL_SWITCH    = 3'h4;
  localparam logic [2:0]  SEL_PIN       = 3'h5;
  localparam logic [1:0]  TC_OFF        = 2'h0;
  localparam logic [1:0]  TC_SENSE      = 2'h1;
  localparam logic [1:0]  TC_BALANCE    = 2'h2;
  localparam logic [1:0]  TC_SHUNT      = 2'h3;
  localparam int          DONE_CELL     = 0;
  localparam int          DONE_SENSE_OW = 1;
  localparam int          DONE_BAL_OW   = 2;
  localparam int          DONE_SWITCH   = 3;
  localparam int          DONE_PIN      = 4;
  localparam int          NUM_DONE      = 5;
  typedef enum logic [1:0] {ACD_IDLE, ACD_SETTLE, ACD_SCAN, ACD_FINISH} acd_state_t;
endpackage : acd_pkg

//--- logic/acd_cmp_if.sv
// Purpose: carrier between the scan engine and the per-channel comparator
// Assumes: single clock
// Notes:   combinational compare path
`timescale 1ns/1ps
`default_nettype none
interface acd_cmp_if;
  logic [2:0]  mode;
  logic [15:0] main_rdg;
  logic [15:0] aux_rdg;
  logic [15:0] thr;
  logic        pass;
  modport engine (output mode, output main_rdg, output aux_rdg, output thr, input pass);
  modport cmp    (input mode, input main_rdg, input aux_rdg, input thr, output pass);
endinterface : acd_cmp_if
`default_nettype wire

//--- logic/acd_compare.sv
// Purpose: pass/fail decision for one channel
// Assumes: readings unsigned, same scale on both converters
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module acd_compare (
  acd_cmp_if.cmp c
);
  import acd_pkg::*;
  logic [15:0] delta;
  logic [17:0] aux_x3;
  always_comb begin
    delta  = (c.main_rdg > c.aux_rdg) ? c.main_rdg - c.aux_rdg : c.aux_rdg - c.main_rdg;
    aux_x3 = {2'b00, c.aux_rdg} + {1'b0, c.aux_rdg, 1'b0};
    case (c.mode)
      SEL_CELL, SEL_PIN:        c.pass = delta < c.thr;
      // open wire is flagged when the reading falls below threshold
      SEL_SENSE_OW, SEL_BAL_OW: c.pass = !(c.main_rdg < c.thr);
      // aux below a third of main, done without a divider
      SEL_SWITCH:               c.pass = aux_x3 < {2'b00, c.main_rdg};
      default:                  c.pass = 1'b1;
    endcase
  end
endmodule : acd_compare
`default_nettype wire

//--- testbench/adc_compare_diag_control_tb_top.sv
// Purpose: self-checking bench for the comparison diagnostic control block
// Assumes: zero-wait AHB-Lite slave, word transfers only
// Notes:   readings are driven far from thresholds so only the decision matters
`timescale 1ns/1ps
`default_nettype none
module adc_compare_diag_control_tb_top;
  import acd_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, shunt_source_en, irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [255:0] main_cell_reading, secondary_cell_reading;
  logic [127:0] main_pin_reading, secondary_pin_reading;
  logic [15:0] active_cell, cell_sense_sink_en, balance_sink_en, balance_switch;
  logic [7:0]  pin_analog_en;
  int          fails, checked;

  acd_diag_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .main_cell_reading(main_cell_reading), .secondary_cell_reading(secondary_cell_reading),
    .main_pin_reading(main_pin_reading), .secondary_pin_reading(secondary_pin_reading),
    .active_cell(active_cell), .pin_analog_en(pin_analog_en),
    .cell_sense_sink_en(cell_sense_sink_en), .balance_sink_en(balance_sink_en),
    .shunt_source_en(shunt_source_en), .balance_switch(balance_switch), .irq(irq));

  always #10 hclk = ~hclk;

  task automatic report_and_stop();
    $display("mismatches %0d of %0d comparisons", fails, checked);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic ahb_xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
                          output logic [31:0] rd);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {20'h00000, a}; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(32'(hresp), 32'h0, "response");
  endtask : ahb_xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    ahb_xfer(a, 1'b1, wd, x);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] x;
    ahb_xfer(a, 1'b0, 32'h0, x);
    check(x, exp, msg);
  endtask : rd_chk

  function automatic logic [31:0] ctrl(logic [2:0] s, logic [1:0] t, logic h, logic g);
    return 32'({h, t, s, g});
  endfunction : ctrl

  task automatic run_diag(input logic [2:0] s, input logic [1:0] t, input logic h,
                          input int b, input logic [15:0] fmap);
    int n;
    wr(CTRL_OFS, ctrl(s, t, h, 1'b1));
    ahb_xfer(STATUS_OFS, 1'b0, 32'h0, d);
    check(32'(d[5]), 32'h1, "busy after trigger");
    n = 0;
    do begin
      ahb_xfer(STATUS_OFS, 1'b0, 32'h0, d);
      n++;
    end while (d[b] !== 1'b1 && n < 100);
    check(d & 32'h3F, 32'h1 << b, "done flag");
    rd_chk(RESULT_OFS, 32'(fmap), "fail map");
    repeat (30) @(posedge hclk);
    rd_chk(STATUS_OFS, 32'h1 << b, "sticky done");
    wr(STATUS_OFS, 32'h1F);
    rd_chk(STATUS_OFS, 32'h0, "done cleared");
    $display("test of selection %0d done", s);
  endtask : run_diag

  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0;
    hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2; fails = 0; checked = 0;
    main_cell_reading = {16{16'h4000}}; secondary_cell_reading = {16{16'h4000}};
    main_pin_reading = {8{16'h4000}}; secondary_pin_reading = {8{16'h4000}};
    active_cell = 16'h00F0; pin_analog_en = 8'h81;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(CTRL_OFS, 32'(CTRL_RESET), "control reset");
    rd_chk(STATUS_OFS, 32'h0, "status reset");
    check({15'h0, irq, balance_switch}, 32'h0, "outputs reset");
    $display("test reset done");
    for (int t = 0; t < 4; t++) begin
      wr(CTRL_OFS, ctrl(3'h0, 2'(t), 1'b0, 1'b0));
      repeat (2) @(posedge hclk);
      check({cell_sense_sink_en, balance_sink_en},
            {(t == 1) ? 16'hFFFF : 16'h0, (t == 2) ? 16'hFFFF : 16'h0}, "sinks");
      check(32'(shunt_source_en), 32'(t == 3), "shunt source");
      rd_chk(STATUS_OFS, 32'h0, "zero trigger idle");
    end
    $display("test of current selection done");
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_OFS, ctrl((i == 0) ? 3'h0 : 3'(5 + i), TC_OFF, 1'b0, 1'b1));
      repeat (40) @(posedge hclk);
      rd_chk(STATUS_OFS, 32'h0, "unused selection");
      rd_chk(CTRL_OFS, ctrl((i == 0) ? 3'h0 : 3'(5 + i), TC_OFF, 1'b0, 1'b0), "go reads 0");
    end
    $display("test of unused selections done");
    // readings held steady as in continuous mode
    secondary_cell_reading[16*3+:16] <= 16'h5000;
    wr(THR_OFS, 32'h0FF8);
    wr(SEL_OFS, 32'h000F);
    wr(IRQ_MASK_OFS, 32'h0);
    wr(CTRL_OFS, ctrl(SEL_CELL, TC_OFF, 1'b0, 1'b1));
    repeat (60) @(posedge hclk);
    check(32'(irq), 32'h0, "masked irq");
    wr(IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge hclk);
    check(32'(irq), 32'h1, "unmasked irq");
    wr(STATUS_OFS, 32'h1);
    repeat (2) @(posedge hclk);
    check(32'(irq), 32'h0, "cleared irq");
    run_diag(SEL_CELL, TC_OFF, 1'b0, DONE_CELL, 16'h0008);
    wr(CTRL_OFS, ctrl(SEL_SENSE_OW, TC_OFF, 1'b0, 1'b0));
    repeat (40) @(posedge hclk);
    rd_chk(STATUS_OFS, 32'h0, "selection not captured");
    secondary_cell_reading[16*3+:16] <= 16'h4000;
    main_cell_reading[16*5+:16] <= 16'h0000;
    main_cell_reading[16*9+:16] <= 16'h0000;
    // host turns the sense sinks on first
    wr(CTRL_OFS, ctrl(3'h0, TC_SENSE, 1'b0, 1'b0));
    run_diag(SEL_SENSE_OW, TC_SENSE, 1'b0, DONE_SENSE_OW, 16'h0020);
    main_cell_reading <= {16{16'h4000}};
    secondary_cell_reading[16*2+:16] <= 16'h0000;
    wr(CTRL_OFS, ctrl(3'h0, TC_BALANCE, 1'b0, 1'b0));
    run_diag(SEL_BAL_OW, TC_BALANCE, 1'b0, DONE_BAL_OW, 16'h0004);
    wr(CTRL_OFS, ctrl(3'h0, TC_OFF, 1'b0, 1'b0));
    secondary_cell_reading <= {{13{16'h4000}}, 16'h4000, 16'h4000, 16'h0000};
    wr(SEL_OFS, 32'h0005);
    // switch mask set first; hold option goes with the trigger write
    wr(MASK_OFS, 32'h00A5);
    run_diag(SEL_SWITCH, TC_OFF, 1'b1, DONE_SWITCH, 16'h0004);
    check(32'(balance_switch), 32'h00A5, "switches held");
    run_diag(SEL_SWITCH, TC_OFF, 1'b0, DONE_SWITCH, 16'h0004);
    repeat (2) @(posedge hclk);
    check(32'(balance_switch), 32'h0, "switches paused");
    secondary_pin_reading[16*7+:16] <= 16'h5000;
    secondary_pin_reading[16*1+:16] <= 16'h5000;
    run_diag(SEL_PIN, TC_OFF, 1'b0, DONE_PIN, 16'h0080);
    rd_chk(THR_OFS, 32'h0000_0FF8, "threshold readback");
    rd_chk(SEL_OFS, 32'h0000_0005, "channel select readback");
    rd_chk(MASK_OFS, 32'h0000_00A5, "switch mask readback");
    rd_chk(IRQ_MASK_OFS, 32'h0000_0001, "irq mask readback");
    main_cell_reading[16*6+:16] <= 16'h1234;
    wr(RDG_IDX_OFS, 32'h0000_0006);
    rd_chk(RDG_IDX_OFS, 32'h0000_0006, "reading index");
    rd_chk(RDG_DATA_OFS, 32'h0000_1234, "reading dump");
    $display("test of register readback done");
    wr(12'h040, 32'hFFFF_FFFF);
    rd_chk(12'h040, 32'h0, "unmapped read");
    $display("test of unmapped address done");
    report_and_stop();
  end

  initial begin
    repeat (30000) @(posedge hclk);
    fails++;
    report_and_stop();
  end
endmodule : adc_compare_diag_control_tb_top
`default_nettype wire
